// ### rtl/srif_consts.svh
// Constants for the sector retry, interleave and format sequencer
`ifndef SRIF_CONSTS_SVH
`define SRIF_CONSTS_SVH
`define SRIF_OP_RECAL      8'h01
`define SRIF_OP_FMT_DISK   8'h04
`define SRIF_OP_FMT_TRACK  8'h06
`define SRIF_OP_FMT_BAD    8'h07
`define SRIF_OP_READ       8'h08
`define SRIF_B5_RETRY_BIT  7
`define SRIF_B5_NOREREAD_BIT 6
`define SRIF_RETRY_RELOAD  3'h4
`define SRIF_FILL_BYTE     8'h6c
`define SRIF_ERR_NONE      8'h00
`define SRIF_ERR_BADTRK    8'h19
`define SRIF_ERR_UNCORR    8'h11
`define SRIF_ERR_FORMAT    8'h14
`define SRIF_ECC_TIME_MS   50
`define SRIF_CLK_HZ        40000000
`define SRIF_ECC_CYCLES    ((`SRIF_ECC_TIME_MS * `SRIF_CLK_HZ) / 1000)
`endif

// ### rtl/srif_pkg.sv
// Types for the sector retry, interleave and format sequencer
package srif_pkg;
  typedef enum logic [3:0] {
    SRIF_IDLE, SRIF_SEEK0, SRIF_FMT, SRIF_FMT_WAIT, SRIF_RD, SRIF_RD_WAIT,
    SRIF_ECC, SRIF_XFER, SRIF_DONE
  } srif_state_t;
  typedef struct packed {
    logic [7:0]  opcode;
    logic [20:0] lba;
    logic [7:0]  count;
    logic [7:0]  interleave;
    logic [7:0]  ctrl;
  } srif_cmd_t;
  typedef struct packed {
    logic        valid;
    logic        done;
    logic        data_err;
    logic        correctable;
    logic        id_bad;
  } srif_disk_rsp_t;
  typedef struct packed {
    logic        rd;
    logic        fmt;
    logic        bad_flag;
    logic        recal;
    logic [20:0] track;
    logic [7:0]  phys_sec;
    logic [7:0]  fill;
  } srif_disk_req_t;
  typedef struct packed {
    logic [7:0]  code;
    logic [20:0] addr;
  } srif_sense_t;
endpackage

// ### rtl/srif_seq.sv
// Sector retry, interleave and format sequencer
`timescale 1ns/100ps
`include "srif_consts.svh"
module srif_seq #(
  parameter int          SPT         = 32,
  parameter int          TRACKS      = 1224,
  parameter int unsigned ECC_CYCLES  = `SRIF_ECC_CYCLES,
  parameter int          REV_SECTORS = 32
) (
  input  wire logic                    CLK_SYS,
  input  wire logic                    RST,
  input  wire logic                    CMD_VALID,
  input  wire srif_pkg::srif_cmd_t     CMD,
  output logic                         CMD_READY,
  input  wire srif_pkg::srif_disk_rsp_t DISK_RSP,
  output srif_pkg::srif_disk_req_t     DISK_REQ,
  input  wire logic                    SECTOR_PULSE,
  input  wire logic                    HOST_DRAINED,
  output logic                         XFER_START,
  output logic                         DATA_ERR_FLAG,
  output logic                         CMD_DONE,
  output srif_pkg::srif_sense_t        SENSE
);
  import srif_pkg::*;

  typedef struct packed {
    srif_state_t    st;
    srif_cmd_t      cmd;
    srif_disk_req_t req;
    srif_sense_t    sense;
    logic [2:0]     retry;
    logic           reread_used;
    logic [31:0]    wait_cnt;
    logic [7:0]     sec_left;
    logic [7:0]     log_sec;
    logic [7:0]     gap_left;
    logic           xfer;
    logic           err_flag;
    logic           done;
    logic           sp_s1;
    logic           sp_s2;
    logic           sp_prev;
  } srif_regs_t;

  srif_regs_t r_q;
  srif_regs_t r_d;

  // Logical-to-physical sector placement, wraps modulo sectors per track
  function automatic logic [7:0] phys_of(input logic [7:0] lsec, input logic [7:0] ilv);
    logic [15:0] p;
    p = 16'(lsec) * 16'(ilv == 8'h00 ? 8'h01 : ilv);
    return 8'(p % 16'(SPT));
  endfunction

  logic        sec_edge;
  logic [7:0]  ilv_ok;
  assign sec_edge  = r_q.sp_s2 & ~r_q.sp_prev;
  assign ilv_ok    = (CMD.interleave > 8'(SPT - 1)) ? 8'(SPT - 1) : CMD.interleave;
  assign CMD_READY = (r_q.st == SRIF_IDLE);

  always_comb
  begin
    r_d         = r_q;
    r_d.sp_s1   = SECTOR_PULSE;
    r_d.sp_s2   = r_q.sp_s1;
    r_d.sp_prev = r_q.sp_s2;
    r_d.xfer    = 1'b0;
    r_d.done    = 1'b0;
    r_d.req.rd  = 1'b0;
    r_d.req.fmt = 1'b0;
    r_d.req.recal = 1'b0;
    case (r_q.st)
      SRIF_IDLE:
      begin
        if (CMD_VALID)
        begin
          r_d.cmd        = CMD;
          r_d.cmd.interleave = ilv_ok;
          r_d.sense.code = `SRIF_ERR_NONE;
          r_d.err_flag   = 1'b0;
          r_d.req.track  = CMD.lba;
          r_d.req.fill   = `SRIF_FILL_BYTE;
          r_d.req.bad_flag = (CMD.opcode == `SRIF_OP_FMT_BAD);
          r_d.retry      = `SRIF_RETRY_RELOAD;
          r_d.reread_used = 1'b0;
          r_d.log_sec    = 8'h00;
          r_d.sec_left   = (CMD.count == 8'h00) ? 8'h01 : CMD.count;
          case (CMD.opcode)
            `SRIF_OP_RECAL:                      r_d.st = SRIF_SEEK0;
            `SRIF_OP_FMT_DISK, `SRIF_OP_FMT_TRACK,
            `SRIF_OP_FMT_BAD:                    r_d.st = SRIF_FMT;
            `SRIF_OP_READ:                       r_d.st = SRIF_RD;
            default:                             r_d.st = SRIF_DONE;
          endcase
        end
      end
      SRIF_SEEK0:
      begin
        r_d.req.recal = 1'b1;
        r_d.req.track = 21'h0;
        if (DISK_RSP.done)
          r_d.st = SRIF_DONE;
      end
      SRIF_FMT:
      begin
        // flag in every ID when bad-track format
        r_d.req.fmt      = 1'b1;
        r_d.req.phys_sec = phys_of(r_q.log_sec, r_q.cmd.interleave);
        r_d.st           = SRIF_FMT_WAIT;
      end
      SRIF_FMT_WAIT:
      begin
        if (DISK_RSP.done)
        begin
          if (DISK_RSP.data_err)
          begin
            r_d.sense.code = `SRIF_ERR_FORMAT;
            r_d.sense.addr = r_q.req.track;
            r_d.st         = SRIF_DONE;
          end
          else if (r_q.log_sec != 8'(SPT - 1))
          begin
            r_d.log_sec = r_q.log_sec + 8'h01;
            r_d.st      = SRIF_FMT;
          end
          // continue to end of disk
          // A start track past the end must not run on until the address wraps
          else if (r_q.cmd.opcode == `SRIF_OP_FMT_DISK && r_q.req.track < 21'(TRACKS - 1))
          begin
            r_d.log_sec   = 8'h00;
            r_d.req.track = r_q.req.track + 21'h1;
            r_d.st        = SRIF_FMT;
          end
          else
            r_d.st = SRIF_DONE;
        end
      end
      SRIF_RD:
      begin
        r_d.req.rd       = 1'b1;
        r_d.req.phys_sec = phys_of(r_q.log_sec, r_q.cmd.interleave);
        r_d.st           = SRIF_RD_WAIT;
      end
      SRIF_RD_WAIT:
      begin
        if (DISK_RSP.done)
        begin
          if (DISK_RSP.id_bad)
          begin
            r_d.sense.code = `SRIF_ERR_BADTRK;
            r_d.sense.addr = r_q.req.track;
            r_d.st         = SRIF_DONE;
          end
          else if (!DISK_RSP.data_err || DISK_RSP.correctable)
          begin
            r_d.retry       = `SRIF_RETRY_RELOAD;
            r_d.reread_used = 1'b0;
            r_d.xfer        = 1'b1;
            r_d.gap_left    = r_q.cmd.interleave;
            r_d.st          = SRIF_XFER;
          end
          else
          begin
            r_d.wait_cnt = 32'(ECC_CYCLES);
            r_d.st       = SRIF_ECC;
          end
        end
      end
      SRIF_ECC:
      begin
        if (r_q.wait_cnt != 32'h0)
          r_d.wait_cnt = r_q.wait_cnt - 32'h1;
        else if (!r_q.reread_used && !r_q.cmd.ctrl[`SRIF_B5_NOREREAD_BIT])
        begin
          r_d.reread_used = 1'b1;
          r_d.st          = SRIF_RD;
        end
        else if (r_q.cmd.ctrl[`SRIF_B5_RETRY_BIT] && r_q.retry != 3'h0)
        begin
          r_d.retry = r_q.retry - 3'h1;
          r_d.st    = SRIF_RD;
        end
        else
        begin
          r_d.err_flag   = 1'b1;
          r_d.sense.code = `SRIF_ERR_UNCORR;
          r_d.sense.addr = r_q.req.track;
          r_d.st         = SRIF_DONE;
        end
      end
      SRIF_XFER:
      begin
        if (r_q.sec_left == 8'h01)
        begin
          if (HOST_DRAINED)
            r_d.st = SRIF_DONE;
        end
        // drained within gap, else a revolution
        else if (sec_edge)
        begin
          if (r_q.gap_left > 8'h01)
            r_d.gap_left = r_q.gap_left - 8'h01;
          else if (HOST_DRAINED)
          begin
            r_d.sec_left = r_q.sec_left - 8'h01;
            r_d.log_sec  = 8'((r_q.log_sec + 8'h01) % 8'(SPT));
            r_d.st       = SRIF_RD;
          end
          else
            r_d.gap_left = 8'(REV_SECTORS);
        end
      end
      SRIF_DONE:
      begin
        r_d.done = 1'b1;
        r_d.st   = SRIF_IDLE;
      end
      default: r_d.st = SRIF_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign DISK_REQ      = r_q.req;
  assign XFER_START    = r_q.xfer;
  assign DATA_ERR_FLAG = r_q.err_flag;
  assign CMD_DONE      = r_q.done;
  assign SENSE         = r_q.sense;

  reload_clean_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (r_q.st == SRIF_RD_WAIT && DISK_RSP.done && !DISK_RSP.data_err && !DISK_RSP.id_bad)
      |=> r_q.retry == `SRIF_RETRY_RELOAD)
    else $error("retry not reloaded");
  bad_track_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (r_q.st == SRIF_RD_WAIT && DISK_RSP.done && DISK_RSP.id_bad)
      |=> r_q.sense.code == `SRIF_ERR_BADTRK ##1 CMD_DONE)
    else $error("bad track not reported");
  reread_go_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (r_q.st == SRIF_ECC && r_q.wait_cnt == 0 && !r_q.reread_used
      && !r_q.cmd.ctrl[`SRIF_B5_NOREREAD_BIT]) |=> r_q.st == SRIF_RD ##1 DISK_REQ.rd)
    else $error("re-read missing");
  no_retry_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (r_q.st == SRIF_ECC && r_q.wait_cnt == 0 && r_q.reread_used
      && !r_q.cmd.ctrl[`SRIF_B5_RETRY_BIT]) |=> r_q.st == SRIF_DONE)
    else $error("retry without enable");
  exhaust_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (r_q.st == SRIF_ECC && r_q.wait_cnt == 0 && r_q.reread_used && r_q.retry == 0)
      |=> DATA_ERR_FLAG && SENSE.code == `SRIF_ERR_UNCORR)
    else $error("uncorrectable not flagged");
  ecc_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (r_q.st == SRIF_ECC && r_q.wait_cnt != 0) |=> r_q.st == SRIF_ECC && !DISK_REQ.rd)
    else $error("read during correction");
  fill_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    DISK_REQ.fmt |-> DISK_REQ.fill == `SRIF_FILL_BYTE)
    else $error("wrong fill byte");
  recal_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    DISK_REQ.recal |-> DISK_REQ.track == 0)
    else $error("recal not to zero");
  fmt_err_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (r_q.st == SRIF_FMT_WAIT && DISK_RSP.done && DISK_RSP.data_err)
      |=> SENSE.addr == $past(r_q.req.track) ##1 CMD_DONE)
    else $error("format error address wrong");
  place_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (r_q.st == SRIF_FMT) |=> DISK_REQ.phys_sec == phys_of($past(r_q.log_sec),
      r_q.cmd.interleave))
    else $error("wrong physical sector");

  fmt_cov_c:  cover property (@(posedge CLK_SYS) r_q.st == SRIF_FMT_WAIT ##1 r_q.st == SRIF_FMT);
  retry_cov_c: cover property (@(posedge CLK_SYS) r_q.st == SRIF_ECC ##1 r_q.st == SRIF_RD);
  rev_cov_c:  cover property (@(posedge CLK_SYS) r_q.st == SRIF_XFER && sec_edge
    && r_q.gap_left <= 1 && !HOST_DRAINED && r_q.sec_left > 1);
  done_cov_c: cover property (@(posedge CLK_SYS) CMD_DONE && SENSE.code == `SRIF_ERR_NONE);
endmodule

// ### tb/srif_disk_model.sv
// Behavioural disk drive partner for the sequencer
`timescale 1ns/100ps
module srif_disk_model #(
  parameter int PERIOD = 8
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire srif_pkg::srif_disk_req_t req,
  input  wire logic [15:0]              fail_mask,
  input  wire logic [15:0]              fix_mask,
  input  wire logic [20:0]              fail_trk,
  output srif_pkg::srif_disk_rsp_t      rsp,
  output logic                          sector_pulse
);
  import srif_pkg::*;
  int          tick;
  int          wait_n;
  int          idx;
  logic [15:0] mask_q;
  logic [20:0] bad_trk;
  logic        bad_ok;
  logic        recal_q;
  logic [2:0]  flg;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tick = 0;
      wait_n = 0;
      bad_ok = 0;
      recal_q = 0;
      flg = '0;
      rsp <= '0;
      sector_pulse <= 1'b0;
    end
    else
    begin
      tick = (tick + 1) % PERIOD;
      sector_pulse <= (tick < 2);
      // New fail pattern restarts its read index
      if (mask_q !== fail_mask)
        idx = 0;
      mask_q = fail_mask;
      // Flags are garbage outside the done cycle
      rsp <= (wait_n == 1) ? {2'b11, flg} : {2'b00, ~flg};
      if (wait_n > 0)
        wait_n--;
      else if (req.rd)
      begin
        // flagged ID fails
        // A fix_mask bit reports an error that the correction logic can repair
        flg[2] = idx < 16 && (fail_mask[idx[3:0]] || fix_mask[idx[3:0]]);
        flg[1] = idx < 16 && fix_mask[idx[3:0]];
        flg[0] = bad_ok && req.track == bad_trk;
        idx++;
        wait_n = 3;
      end
      else if (req.fmt)
      begin
        flg = {req.track == fail_trk, 2'b00};
        if (req.bad_flag)
        begin
          bad_trk = req.track;
          bad_ok = 1;
        end
        wait_n = 3;
      end
      else if (req.recal && !recal_q)
      begin
        flg = '0;
        wait_n = 3;
      end
      recal_q = req.recal;
    end
  end
endmodule

// ### tb/tb_srif_seq.sv
// Self-checking bench for the sector sequencer
`timescale 1ns/100ps
module tb_srif_seq;
  import srif_pkg::*;
  localparam int SPT = 8;
  localparam int TRACKS = 6;
  localparam int ECC = 10;
  localparam int REV = 8;
  localparam int PER = 8;
  logic           CLK_SYS, RST, CMD_VALID, CMD_READY, SECTOR_PULSE;
  logic           HOST_DRAINED, XFER_START, DATA_ERR_FLAG, CMD_DONE, recal_seen;
  srif_cmd_t      CMD;
  srif_disk_rsp_t DISK_RSP;
  srif_disk_req_t DISK_REQ;
  srif_sense_t    SENSE;
  logic [15:0]    fmask, cmask;
  logic [20:0]    ftrk, fmt_trk;
  int             miscompares, checks, cyc, since, drain_dly, xfers, fmts, bads, fills_bad;
  int             rd_phys[$], rd_trk[$], rd_cyc[$];
  srif_seq #(.SPT(SPT), .TRACKS(TRACKS), .ECC_CYCLES(ECC), .REV_SECTORS(REV)) srif_seq_inst (
    .CLK_SYS(CLK_SYS), .RST(RST), .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(CMD_READY),
    .DISK_RSP(DISK_RSP), .DISK_REQ(DISK_REQ), .SECTOR_PULSE(SECTOR_PULSE),
    .HOST_DRAINED(HOST_DRAINED), .XFER_START(XFER_START), .DATA_ERR_FLAG(DATA_ERR_FLAG),
    .CMD_DONE(CMD_DONE), .SENSE(SENSE));
  srif_disk_model #(.PERIOD(PER)) srif_disk_model_inst (
    .clk(CLK_SYS), .rst(RST), .req(DISK_REQ), .fail_mask(fmask), .fix_mask(cmask),
    .fail_trk(ftrk),
    .rsp(DISK_RSP), .sector_pulse(SECTOR_PULSE));
  initial
  begin
    CLK_SYS = 0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end
  // Log what the sequencer asks of the drive
  always @(posedge CLK_SYS)
  begin
    cyc++;
    if (DISK_REQ.rd === 1'b1)
    begin
      rd_phys.push_back(DISK_REQ.phys_sec);
      rd_trk.push_back(DISK_REQ.track);
      rd_cyc.push_back(cyc);
    end
    if (DISK_REQ.fmt === 1'b1)
    begin
      fmts++;
      bads += DISK_REQ.bad_flag;
      fills_bad += (DISK_REQ.fill !== 8'h6c);
      fmt_trk = DISK_REQ.track;
    end
    if (DISK_REQ.recal === 1'b1)
      recal_seen = 1;
    if (XFER_START === 1'b1)
      xfers++;
  end
  // Host empties the buffer drain_dly cycles after each hand-over
  always @(negedge CLK_SYS)
  begin
    since = (XFER_START === 1'b1) ? 0 : since + 1;
    HOST_DRAINED <= (since >= drain_dly);
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic run_cmd(input logic [7:0] op, input int trk, input int cnt, input int ilv,
                         input logic [7:0] ctl);
    int n;
    rd_phys.delete();
    rd_trk.delete();
    rd_cyc.delete();
    {fmts, bads, fills_bad, xfers, recal_seen} = '0;
    @(negedge CLK_SYS);
    check("ready", CMD_READY, 1);
    CMD = '{op, trk[20:0], cnt[7:0], ilv[7:0], ctl};
    CMD_VALID = 1;
    @(negedge CLK_SYS);
    CMD_VALID = 0;
    n = 0;
    while (CMD_DONE !== 1'b1 && n < 5000)
    begin
      @(negedge CLK_SYS);
      n++;
    end
    if (CMD_DONE !== 1'b1)
    begin
      miscompares++;
      print_verdict();
    end
    @(negedge CLK_SYS);
  endtask
  task automatic t_recal;
    run_cmd(8'h01, 0, 0, 0, 8'h00);
    check("recal", recal_seen, 1);
    check("recal code", SENSE.code, 8'h00);
  endtask
  task automatic t_retry;
    logic [7:0]  ctl_t[8] = '{8'h80, 8'h40, 8'h00, 8'hc0, 8'h80, 8'h80, 8'hc0, 8'hc0};
    logic [15:0] msk_t[8] = '{16'h0001, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h001f, 16'h00f7,
                              16'h003d};
    logic [15:0] fix_t[8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                              16'h0002};
    int          cnt_t[8] = '{1, 1, 1, 1, 1, 1, 2, 2};
    int          rds_t[8] = '{2, 1, 2, 5, 6, 6, 9, 7};
    logic [7:0]  cod_t[8] = '{8'h00, 8'h11, 8'h11, 8'h11, 8'h11, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      fmask = msk_t[i];
      cmask = fix_t[i];
      run_cmd(8'h08, 2, cnt_t[i], 2, ctl_t[i]);
      check("reads", rd_cyc.size(), rds_t[i]);
      check("code", SENSE.code, cod_t[i]);
      check("err flag", DATA_ERR_FLAG, cod_t[i] == 8'h11);
      if (i == 0)
        check("ecc gap", rd_cyc.size() > 1 && rd_cyc[1] - rd_cyc[0] >= ECC + 3, 1);
      fmask = '0;
      cmask = '0;
      @(negedge CLK_SYS);
    end
  endtask
  task automatic t_ilv;
    run_cmd(8'h08, 7, 3, SPT - 1, 8'h00);
    check("xfers", xfers, 3);
    foreach (rd_phys[i])
    begin
      check("phys", rd_phys[i], (i * (SPT - 1)) % SPT);
      check("track", rd_trk[i], 7);
    end
  endtask
  task automatic t_drain(input int dly, input logic late);
    drain_dly = dly;
    run_cmd(8'h08, 1, 2, 2, 8'h00);
    check("rev wait", rd_cyc.size() == 2 && (rd_cyc[1] - rd_cyc[0] >= REV * PER) == late, 1);
    drain_dly = 2;
  endtask
  task automatic t_format;
    run_cmd(8'h06, 5, 0, 3, 8'h00);
    check("fmt count", fmts, SPT);
    check("fill", fills_bad, 0);
    check("fmt track", fmt_trk, 5);
    run_cmd(8'h07, 9, 0, 3, 8'h00);
    check("bad flags", bads, SPT);
    run_cmd(8'h08, 9, 1, 1, 8'h00);
    check("bad code", SENSE.code, 8'h19);
    check("bad data", xfers, 0);
  endtask
  task automatic t_fmt_disk;
    run_cmd(8'h04, 3, 0, 1, 8'h00);
    check("disk count", fmts, 3 * SPT);
    check("disk end", fmt_trk, TRACKS - 1);
    ftrk = 21'h4;
    run_cmd(8'h04, 2, 0, 1, 8'h00);
    check("fmt err", SENSE.code, 8'h14);
    check("fmt addr", SENSE.addr, 21'h4);
    ftrk = '1;
  endtask
  initial
  begin
    {RST, HOST_DRAINED, ftrk} = '1;
    {CMD_VALID, CMD, fmask, cmask, miscompares, checks, cyc} = '0;
    drain_dly = 2;
    since = 100;
    repeat (3) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    RST = 0;
    t_recal();
    t_retry();
    t_ilv();
    t_drain(2, 1'b0);
    t_drain(40, 1'b1);
    t_format();
    t_fmt_disk();
    print_verdict();
  end
endmodule
